// >>> pkg/cab_keys_pkg.sv
// Shared constants for the cab keypad command logic: timing, key map,
// register map and screen states.
// Assumes a single 50 MHz clock and keypad levels synchronous to it.
package cab_keys_pkg;

   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int HALT_HOLD_MS = 1000;
   localparam int HALT_HOLD_CYC = CLK_HZ / 1000 * HALT_HOLD_MS;
   localparam int CNT_W = 26;

   // Decoder function layout
   localparam int NUM_FUNCS = 13;
   localparam int HEADLIGHT_FUNCTION_IDX = 0;
   localparam int MOMENTARY_HORN_FUNCTION_IDX = 2;
   localparam int OFFSET_ADD = 10;
   localparam int MAX_FUNC_IDX = 12;
   localparam int MAX_DIGITS = 4;
   localparam int ADDR_W = 14;

   // Key indices in the debounced key vector
   localparam int NUM_KEYS = 20;
   localparam int KEY_FVIEW_A = 10;
   localparam int KEY_FVIEW_B = 11;
   localparam int KEY_PREFIX = 12;
   localparam int KEY_CANCEL = 13;
   localparam int KEY_CONFIRM = 14;
   localparam int KEY_DIR_A = 15;
   localparam int KEY_DIR_B = 16;
   localparam int KEY_RESET = 17;
   localparam int KEY_SEL_A = 18;
   localparam int KEY_SEL_B = 19;

   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_FUNCS_A = 8'h08;
   localparam logic [7:0] REG_FUNCS_B = 8'h0c;
   localparam logic [7:0] REG_ADDR_A = 8'h10;
   localparam logic [7:0] REG_ADDR_B = 8'h14;
   localparam logic [7:0] REG_SLOTS = 8'h18;

   // Field positions and reset values
   localparam int CTRL_KEYPAD_EN_BIT = 0;
   localparam int CTRL_HALT_CLR_BIT = 1;
   localparam int ST_HALT_BIT = 0;
   localparam int ST_ARMED_BIT = 1;
   localparam int ST_VIEWCAB_BIT = 2;
   localparam int ST_SCREEN_LSB = 3;
   localparam logic CTRL_KEYPAD_EN_RESET = 1'b1;
   localparam logic [7:0] SLOTS_RESET = 8'hff;

   typedef enum logic [2:0] {
      SCR_HOME,
      SCR_FUNC_VIEW,
      SCR_FUNC_NA,
      SCR_ASSIGN_WHAT,
      SCR_ASSIGN_ENTRY,
      SCR_ASSIGNED
   } screen_t;

endpackage

// >>> verilog/key_debouncer.sv
// One keypad key: stable-level filter and a single press pulse.
// Assumes the raw level is synchronous to core_clk.
`timescale 1ns/1ps
module key_debouncer
#(
   parameter logic [cab_keys_pkg::CNT_W-1:0] STABLE_CYC = 26'h007_a120
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Key
   input wire logic rawKey,
   output logic level,
   output logic rise
);

   logic [cab_keys_pkg::CNT_W-1:0] cnt_ff;

   // Level follows raw only after it has differed for the full window
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cnt_ff <= '0;
         level <= 1'b0;
      end
      else if (rawKey == level)
         cnt_ff <= '0;
      else if (cnt_ff >= STABLE_CYC - 1'b1)
      begin
         cnt_ff <= '0;
         level <= rawKey;
      end
      else
         cnt_ff <= cnt_ff + 1'b1;
   end

   // One pulse per accepted press; holding never repeats
   always_ff @(posedge core_clk)
   begin
      if (srst)
         rise <= 1'b0;
      else
         rise <= rawKey && !level && (cnt_ff >= STABLE_CYC - 1'b1);
   end

   property p_single_press;
      @(posedge core_clk) disable iff (srst)
      rise |=> !rise && level;
   endproperty
   a_single_press: assert property (p_single_press)
      else $error("press pulse not single or level not high");

endmodule

// >>> verilog/cab_function_store.sv
// Function on/off state of one cab: latching toggles plus one momentary bit.
// Assumes toggle requests are one-cycle strobes from the keypad logic.
`timescale 1ns/1ps
module cab_function_store
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Requests
   input wire logic toggleStb,
   input wire logic [3:0] toggleIdx,
   input wire logic momHeld,
   // State
   output logic [cab_keys_pkg::NUM_FUNCS-1:0] funcs
);

   localparam logic [cab_keys_pkg::NUM_FUNCS-1:0] MOM_MASK =
      13'h0004;

   // Each bit touched only when addressed; momentary bit tracks the key
   always_ff @(posedge core_clk)
   begin
      if (srst)
         funcs <= '0;
      else
      begin
         for (int i = 0; i < cab_keys_pkg::NUM_FUNCS; i++)
         begin
            if (i == cab_keys_pkg::MOMENTARY_HORN_FUNCTION_IDX)
               funcs[i] <= momHeld;
            else if (toggleStb && toggleIdx == 4'(i))
               funcs[i] <= !funcs[i];
         end
      end
   end

   property p_toggle_one_bit;
      @(posedge core_clk) disable iff (srst)
      toggleStb && toggleIdx <= 4'h0c && toggleIdx != 4'h2 |=>
         ((funcs ^ $past(funcs)) & ~MOM_MASK) == (13'h0001 << $past(toggleIdx));
   endproperty
   a_toggle_one_bit: assert property (p_toggle_one_bit)
      else $error("toggle did not flip exactly the addressed function");

   property p_no_stray_change;
      @(posedge core_clk) disable iff (srst)
      !toggleStb |=> ((funcs ^ $past(funcs)) & ~MOM_MASK) == 13'h0000;
   endproperty
   a_no_stray_change: assert property (p_no_stray_change)
      else $error("function changed without a toggle");

   property p_momentary_follows;
      @(posedge core_clk) disable iff (srst)
      ##1 funcs[cab_keys_pkg::MOMENTARY_HORN_FUNCTION_IDX] == $past(momHeld);
   endproperty
   a_momentary_follows: assert property (p_momentary_follows)
      else $error("momentary function not following its key");

endmodule

// >>> verilog/cab_function_keys_and_halt.sv
// Keypad command logic for the two built-in cabs: function view and
// toggles, cab assignment, global halt, and a small register port.
// Assumes keypad levels synchronous to core_clk and a register master
// that sends one-cycle strobes and takes read data the cycle after.
`timescale 1ns/1ps
module cab_function_keys_and_halt
#(
   parameter int DEBOUNCE_CYC = cab_keys_pkg::DEBOUNCE_CYC,
   parameter int HALT_HOLD_CYC = cab_keys_pkg::HALT_HOLD_CYC
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [31:0] regRdData,
   // Keypad levels, high while pressed
   input wire logic [9:0] digitKeys,
   input wire logic funcViewKeyA,
   input wire logic funcViewKeyB,
   input wire logic prefixKey,
   input wire logic cancel_key,
   input wire logic confirm_key,
   input wire logic dirKeyA,
   input wire logic dirKeyB,
   input wire logic resetKey,
   input wire logic cabSelKeyA,
   input wire logic cabSelKeyB,
   // Display
   output cab_keys_pkg::screen_t screen,
   output logic viewCab,
   output logic [13:0] viewAddr,
   output logic [12:0] viewFuncs,
   output logic offsetArmed,
   // Track signal generator
   output logic haltAll,
   output logic [13:0] cabAddrA,
   output logic [13:0] cabAddrB,
   output logic [12:0] cabFuncsA,
   output logic [12:0] cabFuncsB,
   output logic [7:0] freeSlots
);

   localparam logic [cab_keys_pkg::CNT_W-1:0] HOLD_LAST =
      cab_keys_pkg::CNT_W'(HALT_HOLD_CYC - 1);

   logic [cab_keys_pkg::NUM_KEYS-1:0] keyRaw;
   logic [cab_keys_pkg::NUM_KEYS-1:0] keyLevel;
   logic [cab_keys_pkg::NUM_KEYS-1:0] keyRise;
   logic [cab_keys_pkg::NUM_KEYS-1:0] pulse;
   logic keypadEn_ff;
   logic armed_ff;
   logic momActive_ff;
   logic halt_ff;
   logic target_ff;
   logic [2:0] digCount_ff;
   logic [13:0] accum_ff;
   logic [13:0] nxt_accum;
   logic [cab_keys_pkg::CNT_W-1:0] holdA_ff;
   logic [cab_keys_pkg::CNT_W-1:0] holdB_ff;
   logic [3:0] digVal;
   logic [4:0] offIdx;
   logic digHit;
   logic inView;
   logic viewSel;
   logic selCab;
   logic funcToggle;
   logic [3:0] toggleIdx;
   logic momSet;
   logic swHaltClr;
   logic haltRaise;
   logic haltClear;
   logic [31:0] rdMux;
   logic [31:0] statusWord;

   // Key vector in package index order
   assign keyRaw = {cabSelKeyB, cabSelKeyA, resetKey, dirKeyB, dirKeyA, confirm_key,
                    cancel_key, prefixKey, funcViewKeyB, funcViewKeyA, digitKeys};

   // One filter per key
   for (genvar g = 0; g < cab_keys_pkg::NUM_KEYS; g++)
   begin : g_keys
      key_debouncer #(.STABLE_CYC(cab_keys_pkg::CNT_W'(DEBOUNCE_CYC))) u_deb
      (
         .core_clk(core_clk),
         .srst(srst),
         .rawKey(keyRaw[g]),
         .level(keyLevel[g]),
         .rise(keyRise[g])
      );
   end

   // Screen keys are ignored while software disables the keypad
   assign pulse = keyRise & {cab_keys_pkg::NUM_KEYS{keypadEn_ff}};

   // Lowest pressed digit wins when two land in one cycle
   always_comb
   begin
      digVal = 4'h0;
      for (int i = 9; i >= 0; i--)
      begin
         if (pulse[i])
            digVal = 4'(i);
      end
   end

   assign digHit = |pulse[9:0];
   assign offIdx = {1'b0, digVal} + 5'(cab_keys_pkg::OFFSET_ADD);
   assign inView = (screen == cab_keys_pkg::SCR_FUNC_VIEW);
   assign viewSel = pulse[cab_keys_pkg::KEY_FVIEW_A] || pulse[cab_keys_pkg::KEY_FVIEW_B];
   assign selCab = !pulse[cab_keys_pkg::KEY_FVIEW_A];
   assign nxt_accum = 14'((accum_ff << 3) + (accum_ff << 1) + 14'(digVal));

   // Function toggles only from the view; horn digit is momentary instead unless the offset is armed
   always_comb
   begin
      funcToggle = 1'b0;
      momSet = 1'b0;
      toggleIdx = digVal;
      if (inView && digHit && !pulse[cab_keys_pkg::KEY_CANCEL] && !viewSel)
      begin
         if (armed_ff)
         begin
            toggleIdx = offIdx[3:0];
            funcToggle = (offIdx <= 5'(cab_keys_pkg::MAX_FUNC_IDX));
         end
         else if (digVal == 4'(cab_keys_pkg::MOMENTARY_HORN_FUNCTION_IDX))
            momSet = 1'b1;
         else
            funcToggle = 1'b1;
      end
   end

   // Per-cab function state
   cab_function_store u_funcs_a
   (
      .core_clk(core_clk),
      .srst(srst),
      .toggleStb(funcToggle && !viewCab),
      .toggleIdx(toggleIdx),
      .momHeld(momActive_ff && !viewCab),
      .funcs(cabFuncsA)
   );

   cab_function_store u_funcs_b
   (
      .core_clk(core_clk),
      .srst(srst),
      .toggleStb(funcToggle && viewCab),
      .toggleIdx(toggleIdx),
      .momHeld(momActive_ff && viewCab),
      .funcs(cabFuncsB)
   );

   // Screen sequencing; cancel always wins
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         screen <= cab_keys_pkg::SCR_HOME;
         viewCab <= 1'b0;
      end
      else
      begin
         case (screen)
            cab_keys_pkg::SCR_HOME, cab_keys_pkg::SCR_FUNC_VIEW, cab_keys_pkg::SCR_FUNC_NA:
            begin
               if (pulse[cab_keys_pkg::KEY_CANCEL])
                  screen <= cab_keys_pkg::SCR_HOME;
               else if (viewSel)
               begin
                  viewCab <= selCab;
                  if ((selCab ? cabAddrB : cabAddrA) == 14'h0000)
                     screen <= cab_keys_pkg::SCR_FUNC_NA;
                  else
                     screen <= cab_keys_pkg::SCR_FUNC_VIEW;
               end
               else if (screen == cab_keys_pkg::SCR_HOME && pulse[cab_keys_pkg::KEY_PREFIX])
                  screen <= cab_keys_pkg::SCR_ASSIGN_WHAT;
            end
            cab_keys_pkg::SCR_ASSIGN_WHAT:
            begin
               if (pulse[cab_keys_pkg::KEY_CANCEL])
                  screen <= cab_keys_pkg::SCR_HOME;
               else if (pulse[cab_keys_pkg::KEY_SEL_A] || pulse[cab_keys_pkg::KEY_SEL_B])
                  screen <= cab_keys_pkg::SCR_ASSIGN_ENTRY;
            end
            cab_keys_pkg::SCR_ASSIGN_ENTRY:
            begin
               if (pulse[cab_keys_pkg::KEY_CANCEL])
                  screen <= cab_keys_pkg::SCR_HOME;
               else if (pulse[cab_keys_pkg::KEY_CONFIRM])
                  screen <= cab_keys_pkg::SCR_ASSIGNED;
            end
            default:
            begin
               if (pulse[cab_keys_pkg::KEY_CANCEL])
                  screen <= cab_keys_pkg::SCR_HOME;
            end
         endcase
      end
   end

   // Offset arming: any digit, or leaving the view, disarms it
   always_ff @(posedge core_clk)
   begin
      if (srst)
         armed_ff <= 1'b0;
      else if (!inView || pulse[cab_keys_pkg::KEY_CANCEL] || viewSel || digHit)
         armed_ff <= 1'b0;
      else if (pulse[cab_keys_pkg::KEY_PREFIX])
         armed_ff <= 1'b1;
   end

   // Horn held state; ends on release or when the view is left
   always_ff @(posedge core_clk)
   begin
      if (srst)
         momActive_ff <= 1'b0;
      else if (momSet)
         momActive_ff <= 1'b1;
      else if (!keyLevel[cab_keys_pkg::MOMENTARY_HORN_FUNCTION_IDX] || !inView)
         momActive_ff <= 1'b0;
   end

   // Address entry and cab assignment
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         accum_ff <= '0;
         digCount_ff <= '0;
         target_ff <= 1'b0;
         cabAddrA <= '0;
         cabAddrB <= '0;
         freeSlots <= cab_keys_pkg::SLOTS_RESET;
      end
      else if (screen == cab_keys_pkg::SCR_ASSIGN_WHAT)
      begin
         accum_ff <= '0;
         digCount_ff <= '0;
         target_ff <= !pulse[cab_keys_pkg::KEY_SEL_A];
      end
      else if (screen == cab_keys_pkg::SCR_ASSIGN_ENTRY && !pulse[cab_keys_pkg::KEY_CANCEL])
      begin
         if (pulse[cab_keys_pkg::KEY_CONFIRM])
         begin
            // Empty entry leaves accum at zero: cab unassigned
            if (target_ff)
               cabAddrB <= accum_ff;
            else
               cabAddrA <= accum_ff;
            if (accum_ff != 14'h0000 && target_ff && cabAddrA == accum_ff)
               cabAddrA <= '0;
            if (accum_ff != 14'h0000 && !target_ff && cabAddrB == accum_ff)
               cabAddrB <= '0;
            // Only a new address takes a slot; clearing frees none
            if (accum_ff != 14'h0000 && freeSlots != 8'h00
                && accum_ff != cabAddrA && accum_ff != cabAddrB)
               freeSlots <= freeSlots - 8'h01;
         end
         else if (digHit && digCount_ff < 3'(cab_keys_pkg::MAX_DIGITS))
         begin
            accum_ff <= nxt_accum;
            digCount_ff <= digCount_ff + 3'h1;
         end
      end
   end

   // Direction key hold timers; only built-in cab keys reach this
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         holdA_ff <= '0;
         holdB_ff <= '0;
      end
      else
      begin
         if (!keyLevel[cab_keys_pkg::KEY_DIR_A])
            holdA_ff <= '0;
         else if (holdA_ff != HOLD_LAST)
            holdA_ff <= holdA_ff + 1'b1;
         if (!keyLevel[cab_keys_pkg::KEY_DIR_B])
            holdB_ff <= '0;
         else if (holdB_ff != HOLD_LAST)
            holdB_ff <= holdB_ff + 1'b1;
      end
   end

   assign swHaltClr = regWrStb && regAddr == cab_keys_pkg::REG_CTRL
                      && regWrData[cab_keys_pkg::CTRL_HALT_CLR_BIT];
   // No assignment check: an unassigned cab may still halt everything
   assign haltRaise = (keyLevel[cab_keys_pkg::KEY_DIR_A] && holdA_ff == HOLD_LAST)
                      || (keyLevel[cab_keys_pkg::KEY_DIR_B] && holdB_ff == HOLD_LAST);
   assign haltClear = keyRise[cab_keys_pkg::KEY_DIR_A] || keyRise[cab_keys_pkg::KEY_DIR_B]
                      || keyRise[cab_keys_pkg::KEY_RESET] || swHaltClr;

   // Global halt; speeds are held upstream, so clearing resumes them
   always_ff @(posedge core_clk)
   begin
      if (srst)
         halt_ff <= 1'b0;
      else if (!halt_ff && haltRaise)
         halt_ff <= 1'b1;
      else if (halt_ff && haltClear)
         halt_ff <= 1'b0;
   end

   assign haltAll = halt_ff;
   assign offsetArmed = armed_ff;

   // Registered view for the display
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         viewAddr <= '0;
         viewFuncs <= '0;
      end
      else
      begin
         viewAddr <= viewCab ? cabAddrB : cabAddrA;
         viewFuncs <= viewCab ? cabFuncsB : cabFuncsA;
      end
   end

   // Control register
   always_ff @(posedge core_clk)
   begin
      if (srst)
         keypadEn_ff <= cab_keys_pkg::CTRL_KEYPAD_EN_RESET;
      else if (regWrStb && regAddr == cab_keys_pkg::REG_CTRL)
         keypadEn_ff <= regWrData[cab_keys_pkg::CTRL_KEYPAD_EN_BIT];
   end

   // Read decode; unmapped addresses read zero
   always_comb
   begin
      statusWord = '0;
      statusWord[cab_keys_pkg::ST_HALT_BIT] = halt_ff;
      statusWord[cab_keys_pkg::ST_ARMED_BIT] = armed_ff;
      statusWord[cab_keys_pkg::ST_VIEWCAB_BIT] = viewCab;
      statusWord[cab_keys_pkg::ST_SCREEN_LSB +: 3] = screen;
      if (regAddr == cab_keys_pkg::REG_CTRL)
         rdMux = {31'h0000_0000, keypadEn_ff};
      else if (regAddr == cab_keys_pkg::REG_STATUS)
         rdMux = statusWord;
      else if (regAddr == cab_keys_pkg::REG_FUNCS_A)
         rdMux = {19'h0_0000, cabFuncsA};
      else if (regAddr == cab_keys_pkg::REG_FUNCS_B)
         rdMux = {19'h0_0000, cabFuncsB};
      else if (regAddr == cab_keys_pkg::REG_ADDR_A)
         rdMux = {18'h0_0000, cabAddrA};
      else if (regAddr == cab_keys_pkg::REG_ADDR_B)
         rdMux = {18'h0_0000, cabAddrB};
      else if (regAddr == cab_keys_pkg::REG_SLOTS)
         rdMux = {24'h00_0000, freeSlots};
      else
         rdMux = '0;
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (srst)
         regRdData <= '0;
      else
         regRdData <= regRdStb ? rdMux : 32'h0000_0000;
   end

   property p_cancel_home;
      @(posedge core_clk) disable iff (srst)
      inView && pulse[cab_keys_pkg::KEY_CANCEL] |=>
         screen == cab_keys_pkg::SCR_HOME ##1
         cabFuncsA == $past(cabFuncsA, 2) && cabFuncsB == $past(cabFuncsB, 2);
   endproperty
   a_cancel_home: assert property (p_cancel_home)
      else $error("cancel did not return home cleanly");

   property p_unassigned_na;
      @(posedge core_clk) disable iff (srst)
      screen == cab_keys_pkg::SCR_HOME && pulse[cab_keys_pkg::KEY_FVIEW_A]
         && !pulse[cab_keys_pkg::KEY_CANCEL] && cabAddrA == 14'h0000 |=>
         screen == cab_keys_pkg::SCR_FUNC_NA && !viewCab;
   endproperty
   a_unassigned_na: assert property (p_unassigned_na)
      else $error("unassigned cab did not show not-available");

   property p_no_toggle_outside;
      @(posedge core_clk) disable iff (srst)
      !inView |-> !funcToggle && !momSet;
   endproperty
   a_no_toggle_outside: assert property (p_no_toggle_outside)
      else $error("digit acted on a function outside the view");

   property p_arm;
      @(posedge core_clk) disable iff (srst)
      inView && pulse[cab_keys_pkg::KEY_PREFIX] && !digHit && !viewSel
         && !pulse[cab_keys_pkg::KEY_CANCEL] |=> offsetArmed;
   endproperty
   a_arm: assert property (p_arm)
      else $error("prefix key did not arm the offset");

   property p_disarm;
      @(posedge core_clk) disable iff (srst)
      armed_ff && digHit |-> (toggleIdx == 4'(digVal + 4'ha) || !funcToggle) ##1 !offsetArmed;
   endproperty
   a_disarm: assert property (p_disarm)
      else $error("offset digit wrong or offset still armed");

   property p_empty_confirm;
      @(posedge core_clk) disable iff (srst)
      screen == cab_keys_pkg::SCR_ASSIGN_ENTRY && pulse[cab_keys_pkg::KEY_CONFIRM]
         && !pulse[cab_keys_pkg::KEY_CANCEL] && digCount_ff == 3'h0 |=>
         $stable(freeSlots) && (target_ff ? cabAddrB : cabAddrA) == 14'h0000;
   endproperty
   a_empty_confirm: assert property (p_empty_confirm)
      else $error("empty confirm changed slots or left cab assigned");

   property p_steal;
      @(posedge core_clk) disable iff (srst)
      screen == cab_keys_pkg::SCR_ASSIGN_ENTRY && pulse[cab_keys_pkg::KEY_CONFIRM]
         && !pulse[cab_keys_pkg::KEY_CANCEL] && accum_ff != 14'h0000 |=>
         cabAddrA != cabAddrB;
   endproperty
   a_steal: assert property (p_steal)
      else $error("both cabs hold the same address");

   property p_halt_raise;
      @(posedge core_clk) disable iff (srst)
      !halt_ff && haltRaise |=> haltAll ##1 (haltAll || $past(haltClear));
   endproperty
   a_halt_raise: assert property (p_halt_raise)
      else $error("held direction key did not raise halt");

   property p_halt_clear;
      @(posedge core_clk) disable iff (srst)
      halt_ff && (keyRise[cab_keys_pkg::KEY_DIR_A] || keyRise[cab_keys_pkg::KEY_RESET]) |=>
         !haltAll;
   endproperty
   a_halt_clear: assert property (p_halt_clear)
      else $error("halt not cleared by key press");

   property p_halt_powerup;
      @(posedge core_clk) disable iff (srst)
      $past(srst) |-> !haltAll;
   endproperty
   a_halt_powerup: assert property (p_halt_powerup)
      else $error("halt present after reset");

endmodule

// >>> testbench/cab_keypad_model.sv
// Operator keypad model: key levels seen by the block's keypad inputs.
// Assumes key indices of cab_keys_pkg and one key request per edge.
`timescale 1ns/1ps
module cab_keypad_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Key request from the bench
   input wire logic keyStb,
   input wire logic [4:0] keyIdx,
   input wire logic keyVal,
   // Key levels, high while pressed
   output logic [cab_keys_pkg::NUM_KEYS-1:0] keys
);
   // A key changes one edge after its request; all keys up during reset
   always_ff @(posedge core_clk)
   begin
      if (srst)
         keys <= '0;
      else if (keyStb)
         keys[keyIdx] <= keyVal;
   end
endmodule

// >>> testbench/cab_function_keys_and_halt_tb_top.sv
// Bench for the cab keypad logic: keypad sequences and register reads.
// Assumes short filter and hold counts of 4 and 16 cycles.
`timescale 1ns/1ps
`define CHK(n, e, a) begin #1; compares++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH %s expected %0h seen %0h", n, e, a); end end
module cab_function_keys_and_halt_tb_top;
   logic core_clk = 0;
   logic srst = 1;
   logic [7:0] regAddr = '0;
   logic [31:0] regWrData = '0;
   logic regWrStb = 0;
   logic regRdStb = 0;
   logic keyStb = 0;
   logic [4:0] keyIdx = '0;
   logic keyVal = 0;
   logic [31:0] regRdData;
   logic [19:0] keys;
   cab_keys_pkg::screen_t screen;
   logic viewCab, offsetArmed, haltAll;
   logic [13:0] viewAddr, cabAddrA, cabAddrB;
   logic [12:0] viewFuncs, cabFuncsA, cabFuncsB;
   logic [7:0] freeSlots;
   int fails = 0;
   int compares = 0;
   // Free-running 50 MHz clock
   initial forever #10 core_clk = ~core_clk;
   cab_keypad_model kp (.core_clk(core_clk), .srst(srst), .keyStb(keyStb), .keyIdx(keyIdx),
      .keyVal(keyVal), .keys(keys));
   cab_function_keys_and_halt #(.DEBOUNCE_CYC(4), .HALT_HOLD_CYC(16)) uut (
      .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .digitKeys(keys[9:0]), .funcViewKeyA(keys[10]), .funcViewKeyB(keys[11]),
      .prefixKey(keys[12]), .cancel_key(keys[13]), .confirm_key(keys[14]),
      .dirKeyA(keys[15]), .dirKeyB(keys[16]), .resetKey(keys[17]),
      .cabSelKeyA(keys[18]), .cabSelKeyB(keys[19]), .screen(screen), .viewCab(viewCab),
      .viewAddr(viewAddr), .viewFuncs(viewFuncs), .offsetArmed(offsetArmed),
      .haltAll(haltAll), .cabAddrA(cabAddrA), .cabAddrB(cabAddrB), .cabFuncsA(cabFuncsA),
      .cabFuncsB(cabFuncsB), .freeSlots(freeSlots));
   // Single-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWrStb <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrStb <= 1'b0;
   endtask
   // Read strobe, then data is taken in the one cycle it stands
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      regRdStb <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1 `CHK("regRdData", e, regRdData)
   endtask
   // Key level request; the model applies it one edge later, then n edges pass
   task automatic drive(input int k, input logic v, input int n);
      @(posedge core_clk);
      keyStb <= 1'b1;
      keyIdx <= 5'(k);
      keyVal <= v;
      @(posedge core_clk);
      keyStb <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   // One clean press, then a release longer than the filter
   task automatic press(input int k);
      drive(k, 1'b1, 8);
      drive(k, 1'b0, 10);
   endtask
   // Assignment opens from home only; a digit above 9 confirms an empty number
   task automatic assign_cab(input int sel, input int d);
      press(13);
      press(12);
      press(sel);
      if (d < 10)
         press(d);
      press(14);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog in case a sequence hangs
   initial
   begin
      #1ms;
      fails++;
      results();
   end
   // Main sequence
   initial
   begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK("haltAll", 1'b0, haltAll)
      rdchk(cab_keys_pkg::REG_SLOTS, 32'h0000_00ff);
      rdchk(8'h1c, 32'h0000_0000);
      assign_cab(18, 3);
      assign_cab(19, 3);
      `CHK("cabAddrA", 14'h0000, cabAddrA)
      `CHK("cabAddrB", 14'h0003, cabAddrB)
      press(13);
      $display("assign test done");
      press(11);
      `CHK("screen", cab_keys_pkg::SCR_FUNC_VIEW, screen)
      `CHK("viewCab", 1'b1, viewCab)
      `CHK("viewAddr", 14'h0003, viewAddr)
      press(0);
      `CHK("cabFuncsB", 13'h0001, cabFuncsB)
      `CHK("cabFuncsA", 13'h0000, cabFuncsA)
      press(3);
      `CHK("cabFuncsB", 13'h0009, cabFuncsB)
      press(3);
      `CHK("cabFuncsB", 13'h0001, cabFuncsB)
      drive(2, 1'b1, 12);
      `CHK("cabFuncsB", 13'h0005, cabFuncsB)
      drive(2, 1'b0, 10);
      `CHK("cabFuncsB", 13'h0001, cabFuncsB)
      press(12);
      `CHK("offsetArmed", 1'b1, offsetArmed)
      press(2);
      `CHK("cabFuncsB", 13'h1001, cabFuncsB)
      `CHK("offsetArmed", 1'b0, offsetArmed)
      `CHK("viewFuncs", 13'h1001, viewFuncs)
      press(12);
      press(5);
      `CHK("cabFuncsB", 13'h1001, cabFuncsB)
      `CHK("offsetArmed", 1'b0, offsetArmed)
      press(13);
      `CHK("screen", cab_keys_pkg::SCR_HOME, screen)
      press(4);
      `CHK("cabFuncsB", 13'h1001, cabFuncsB)
      press(10);
      `CHK("screen", cab_keys_pkg::SCR_FUNC_NA, screen)
      press(13);
      wr(cab_keys_pkg::REG_CTRL, 32'h0000_0000);
      press(11);
      `CHK("screen", cab_keys_pkg::SCR_HOME, screen)
      wr(cab_keys_pkg::REG_CTRL, 32'h0000_0001);
      $display("function test done");
      assign_cab(19, 10);
      `CHK("cabAddrB", 14'h0000, cabAddrB)
      `CHK("freeSlots", 8'hfe, freeSlots)
      press(13);
      drive(15, 1'b1, 40);
      drive(15, 1'b0, 10);
      `CHK("haltAll", 1'b1, haltAll)
      rdchk(cab_keys_pkg::REG_STATUS, 32'h0000_0001);
      press(16);
      `CHK("haltAll", 1'b0, haltAll)
      drive(16, 1'b1, 40);
      drive(16, 1'b0, 10);
      `CHK("haltAll", 1'b1, haltAll)
      press(17);
      `CHK("haltAll", 1'b0, haltAll)
      $display("halt test done");
      results();
   end
endmodule
